/* File: design/hld_params.svh */
// Purpose: Constants for the host I/O and legacy decode block
// Assumes: Included by design files by bare name
// Notes: Offsets, field positions and reset values as macros
`ifndef HLD_PARAMS_SVH
`define HLD_PARAMS_SVH
`define HLD_CFG_ADDR_PORT 17'h00cf8
`define HLD_CFG_DATA_PORT 17'h00cfc
`define HLD_VGA_A_LO 32'h000a0000
`define HLD_VGA_A_HI 32'h000affff
`define HLD_MONO_LO 32'h000b0000
`define HLD_MONO_HI 32'h000b7fff
`define HLD_VGA_B_LO 32'h000b8000
`define HLD_VGA_B_HI 32'h000bffff
`define HLD_MAIN_LO 32'h01000000
`define HLD_REG_IO_BASE 4'h0
`define HLD_REG_IO_LIMIT 4'h1
`define HLD_REG_CMD 4'h2
`define HLD_REG_LAC 4'h3
`define HLD_REG_TOP_OF_LOW_DRAM 4'h4
`define HLD_REG_CFG_ADDR 4'h5
`define HLD_REG_STATUS 4'h6
`define HLD_CMD_IO_EN_BIT 0
`define HLD_CMD_MEM_EN_BIT 1
`define HLD_LAC_VGA_EN_BIT 0
`define HLD_LAC_MDA_BIT 1
`define HLD_IO_BASE_RST 16'hffff
`define HLD_IO_LIMIT_RST 16'h0000
`define HLD_TOP_OF_LOW_DRAM_RST 32'h01000000
`define HLD_UR_ADDR 32'h00000000
`endif

/* File: design/hld_pkg.sv */
// Purpose: Types for the host I/O and legacy decode block
// Assumes: Nothing beyond the params header
// Notes: Destinations and request kinds
package hld_pkg;
  typedef enum logic [2:0] {
    HLD_DST_NONE = 3'h0,
    HLD_DST_CFG = 3'h1,
    HLD_DST_PORT = 3'h2,
    HLD_DST_SOUTH = 3'h3,
    HLD_DST_BOTH = 3'h4,
    HLD_DST_DRAM = 3'h5
  } hld_dst_e;
  typedef enum logic [1:0] {
    HLD_K_IO_RD = 2'h0,
    HLD_K_IO_WR = 2'h1,
    HLD_K_MEM_RD = 2'h2,
    HLD_K_MEM_WR = 2'h3
  } hld_kind_e;
endpackage : hld_pkg

/* File: design/hld_route.sv */
// Purpose: Combinational destination decode for one request
// Assumes: Window and control values are registered by the caller
// Notes: Pure logic, no state
`timescale 1ns/1ps
`include "hld_params.svh"
module hld_route
  import hld_pkg::*;
(
  input wire logic is_io,
  input wire logic [31:0] addr,
  input wire logic [15:0] io_base,
  input wire logic [15:0] io_limit,
  input wire logic io_en,
  input wire logic mem_en,
  input wire logic vga_en,
  input wire logic mono_present,
  input wire logic [31:0] top_of_low_dram,
  output hld_dst_e dst
);
  logic in_win;
  logic is_cfg;
  logic in_vga;
  logic in_mono;
  always_comb begin
    in_win = ({15'h0, addr[16:0]} >= {16'h0, io_base}) &&
             ({15'h0, addr[16:0]} <= {16'h0, io_limit});
    is_cfg = ({addr[16:2], 2'h0} == `HLD_CFG_ADDR_PORT) ||
             ({addr[16:2], 2'h0} == `HLD_CFG_DATA_PORT);
    in_vga = ((addr >= `HLD_VGA_A_LO) && (addr <= `HLD_VGA_A_HI)) ||
             ((addr >= `HLD_VGA_B_LO) && (addr <= `HLD_VGA_B_HI));
    in_mono = (addr >= `HLD_MONO_LO) && (addr <= `HLD_MONO_HI);
    dst = HLD_DST_SOUTH;
    if (is_io) begin
      if (is_cfg) begin
        dst = HLD_DST_CFG;
      end else if (in_win && io_en) begin
        dst = HLD_DST_PORT;
      end
    end else if (in_vga) begin
      dst = (vga_en && mem_en) ? HLD_DST_PORT : HLD_DST_SOUTH;
    end else if (in_mono) begin
      if (vga_en && mem_en && !mono_present) begin
        dst = HLD_DST_PORT;
      end else if (vga_en && mem_en) begin
        dst = HLD_DST_SOUTH;
      end else begin
        dst = HLD_DST_SOUTH;
      end
    end else if ((addr >= `HLD_MAIN_LO) && (addr < top_of_low_dram)) begin
      dst = HLD_DST_DRAM;
    end
  end
endmodule : hld_route

/* File: design/hld_top.sv */
// Purpose: Host I/O cycle and legacy range decode bridge
// Assumes: Requests from same-clock host logic, one at a time
// Notes: Downstream links answer with done pulses
// How it works
// - Claim config address and data ports
// - Claim or forward every host I/O
// - Default south link, window goes port
// - Pass I/O address unchanged, bit 16
// - I/O writes non-posted, memory writes posted
// - I/O enable clear blocks port I/O
// - Inbound I/O answered Unsupported Request
// - Inbound I/O/config read address zero
// - Split I/O reads crossing 4-byte boundary
// - Decode VGA, mono and main ranges
// - Steer VGA range by control bits
// - Internal port decoded first
// - VGA enable with memory enable selects port else south
`timescale 1ns/1ps
`include "hld_params.svh"
module hld_top
  import hld_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic host_req,
  input wire logic [1:0] host_kind,
  input wire logic [31:0] host_addr,
  input wire logic host_addr_bit16_n,
  input wire logic [7:0] host_be,
  input wire logic [31:0] host_wdata,
  output logic host_busy,
  output logic host_done,
  output logic [31:0] host_rdata,
  output logic dn_req,
  output logic dn_to_port,
  output logic dn_posted,
  output logic [1:0] dn_kind,
  output logic [31:0] dn_addr,
  output logic [3:0] dn_be,
  output logic [31:0] dn_wdata,
  input wire logic dn_done,
  input wire logic [31:0] dn_rdata,
  input wire logic in_req,
  input wire logic in_is_io_cfg,
  output logic in_mem_rd,
  output logic [31:0] in_mem_addr,
  output logic in_ur
);
  typedef enum logic [1:0] {
    HLD_S_IDLE = 2'h0,
    HLD_S_LOW = 2'h1,
    HLD_S_HIGH = 2'h2
  } hld_st_e;

  logic [15:0] io_base;
  logic [15:0] io_limit;
  logic [1:0] cmd;
  logic [1:0] legacy_access_ctrl;
  logic [31:0] top_of_low_dram;
  logic [31:0] cfg_addr;
  logic [15:0] next_io_base;
  logic [15:0] next_io_limit;
  logic [1:0] next_cmd;
  logic [1:0] next_lac;
  logic [31:0] next_top_of_low_dram;
  logic [31:0] next_cfg_addr;
  logic [31:0] next_reg_rdata;
  logic [7:0] split_cnt;
  logic [7:0] next_split_cnt;

  hld_st_e st;
  hld_st_e next_st;
  logic [31:0] ad;
  logic [31:0] next_ad;
  logic [7:0] be;
  logic [7:0] next_be;
  logic [1:0] kind;
  logic [1:0] next_kind;
  logic [31:0] wd;
  logic [31:0] next_wd;
  logic to_port;
  logic next_to_port;
  logic [31:0] rd_acc;
  logic [31:0] next_rd_acc;
  logic next_host_busy;
  logic next_host_done;
  logic [31:0] next_host_rdata;
  logic next_dn_req;
  logic next_dn_to_port;
  logic next_dn_posted;
  logic [1:0] next_dn_kind;
  logic [31:0] next_dn_addr;
  logic [3:0] next_dn_be;
  logic [31:0] next_dn_wdata;
  logic next_in_mem_rd;
  logic [31:0] next_in_mem_addr;
  logic next_in_ur;

  logic [31:0] full_addr;
  logic req_io;
  logic win_hit;
  hld_dst_e dst;

  always_comb begin
    full_addr = {host_addr[31:17], ~host_addr_bit16_n, host_addr[15:0]};
    req_io = (host_kind == HLD_K_IO_RD) || (host_kind == HLD_K_IO_WR);
    win_hit = cmd[`HLD_CMD_IO_EN_BIT] && (full_addr[16:0] >= {1'b0, io_base})
              && (full_addr[16:0] <= {1'b0, io_limit});
  end

  hld_route u_route (
    .is_io(req_io),
    .addr(full_addr),
    .io_base(io_base),
    .io_limit(io_limit),
    .io_en(cmd[`HLD_CMD_IO_EN_BIT]),
    .mem_en(cmd[`HLD_CMD_MEM_EN_BIT]),
    .vga_en(legacy_access_ctrl[`HLD_LAC_VGA_EN_BIT]),
    .mono_present(legacy_access_ctrl[`HLD_LAC_MDA_BIT]),
    .top_of_low_dram(top_of_low_dram),
    .dst(dst)
  );

  // Register file
  always_comb begin
    next_io_base = io_base;
    next_io_limit = io_limit;
    next_cmd = cmd;
    next_lac = legacy_access_ctrl;
    next_top_of_low_dram = top_of_low_dram;
    next_cfg_addr = cfg_addr;
    next_reg_rdata = 32'h0;
    next_split_cnt = split_cnt;
    if (st == HLD_S_LOW && dn_done && kind == HLD_K_IO_RD &&
        be[3:0] != 4'h0 && be[7:4] != 4'h0) begin
      next_split_cnt = split_cnt + 8'h01;
    end
    if (host_req && !host_busy && kind_is_cfgwr()) begin
      next_cfg_addr = host_wdata;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `HLD_REG_IO_BASE: next_io_base = reg_wdata[15:0];
        `HLD_REG_IO_LIMIT: next_io_limit = reg_wdata[15:0];
        `HLD_REG_CMD: next_cmd = reg_wdata[1:0];
        `HLD_REG_LAC: next_lac = reg_wdata[1:0];
        `HLD_REG_TOP_OF_LOW_DRAM: next_top_of_low_dram = reg_wdata;
        `HLD_REG_CFG_ADDR: next_cfg_addr = reg_wdata;
        default: next_split_cnt = split_cnt;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `HLD_REG_IO_BASE: next_reg_rdata = {16'h0, io_base};
        `HLD_REG_IO_LIMIT: next_reg_rdata = {16'h0, io_limit};
        `HLD_REG_CMD: next_reg_rdata = {30'h0, cmd};
        `HLD_REG_LAC: next_reg_rdata = {30'h0, legacy_access_ctrl};
        `HLD_REG_TOP_OF_LOW_DRAM: next_reg_rdata = top_of_low_dram;
        `HLD_REG_CFG_ADDR: next_reg_rdata = cfg_addr;
        `HLD_REG_STATUS: next_reg_rdata = {21'h0, st, host_busy, split_cnt};
        default: next_reg_rdata = 32'h0;
      endcase
    end
  end

  function automatic logic kind_is_cfgwr();
    kind_is_cfgwr = (dst == HLD_DST_CFG) && (host_kind == HLD_K_IO_WR) &&
                    ({full_addr[16:2], 2'h0} == `HLD_CFG_ADDR_PORT);
  endfunction : kind_is_cfgwr

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_base <= `HLD_IO_BASE_RST;
      io_limit <= `HLD_IO_LIMIT_RST;
      cmd <= 2'h0;
      legacy_access_ctrl <= 2'h0;
      top_of_low_dram <= `HLD_TOP_OF_LOW_DRAM_RST;
      cfg_addr <= 32'h0;
      reg_rdata <= 32'h0;
      split_cnt <= 8'h0;
    end else begin
      io_base <= next_io_base;
      io_limit <= next_io_limit;
      cmd <= next_cmd;
      legacy_access_ctrl <= next_lac;
      top_of_low_dram <= next_top_of_low_dram;
      cfg_addr <= next_cfg_addr;
      reg_rdata <= next_reg_rdata;
      split_cnt <= next_split_cnt;
    end
  end

  // Host request sequencer
  always_comb begin
    next_st = st;
    next_ad = ad;
    next_be = be;
    next_kind = kind;
    next_wd = wd;
    next_to_port = to_port;
    next_rd_acc = rd_acc;
    next_host_busy = host_busy;
    next_host_done = 1'b0;
    next_host_rdata = host_rdata;
    next_dn_req = 1'b0;
    next_dn_to_port = dn_to_port;
    next_dn_posted = dn_posted;
    next_dn_kind = dn_kind;
    next_dn_addr = dn_addr;
    next_dn_be = dn_be;
    next_dn_wdata = dn_wdata;
    unique case (st)
      HLD_S_IDLE: begin
        if (host_req && !host_busy) begin
          if (dst == HLD_DST_CFG) begin
            next_host_done = 1'b1;
            next_host_rdata = (full_addr[2]) ? 32'h0 : cfg_addr;
          end else if (dst == HLD_DST_DRAM) begin
            next_host_done = 1'b1;
            next_host_rdata = 32'h0;
          end else begin
            next_host_busy = 1'b1;
            next_ad = full_addr;
            next_be = host_be;
            next_kind = host_kind;
            next_wd = host_wdata;
            next_to_port = (dst == HLD_DST_PORT);
            next_rd_acc = 32'h0;
            next_dn_req = 1'b1;
            next_dn_to_port = (dst == HLD_DST_PORT);
            next_dn_posted = (host_kind == HLD_K_MEM_WR);
            next_dn_kind = host_kind;
            next_dn_addr = {full_addr[31:3], (host_be[3:0] == 4'h0), 2'h0};
            next_dn_be = (host_be[3:0] != 4'h0) ? host_be[3:0] : host_be[7:4];
            next_dn_wdata = host_wdata;
            next_st = HLD_S_LOW;
          end
        end
      end
      HLD_S_LOW: begin
        if (dn_done) begin
          next_rd_acc = dn_rdata;
          if (kind == HLD_K_IO_RD && be[3:0] != 4'h0 &&
              be[7:4] != 4'h0) begin
            next_dn_req = 1'b1;
            next_dn_addr = {ad[31:3], 3'h4};
            next_dn_be = be[7:4];
            next_dn_to_port = to_port;
            next_dn_wdata = wd;
            next_st = HLD_S_HIGH;
          end else begin
            next_host_done = 1'b1;
            next_host_rdata = dn_rdata;
            next_host_busy = 1'b0;
            next_st = HLD_S_IDLE;
          end
        end
      end
      HLD_S_HIGH: begin
        if (dn_done) begin
          next_host_done = 1'b1;
          next_host_rdata = rd_acc | dn_rdata;
          next_host_busy = 1'b0;
          next_st = HLD_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= HLD_S_IDLE;
      ad <= 32'h0;
      be <= 8'h0;
      kind <= 2'h0;
      wd <= 32'h0;
      to_port <= 1'b0;
      rd_acc <= 32'h0;
      host_busy <= 1'b0;
      host_done <= 1'b0;
      host_rdata <= 32'h0;
      dn_req <= 1'b0;
      dn_to_port <= 1'b0;
      dn_posted <= 1'b0;
      dn_kind <= 2'h0;
      dn_addr <= 32'h0;
      dn_be <= 4'h0;
      dn_wdata <= 32'h0;
    end else begin
      st <= next_st;
      ad <= next_ad;
      be <= next_be;
      kind <= next_kind;
      wd <= next_wd;
      to_port <= next_to_port;
      rd_acc <= next_rd_acc;
      host_busy <= next_host_busy;
      host_done <= next_host_done;
      host_rdata <= next_host_rdata;
      dn_req <= next_dn_req;
      dn_to_port <= next_dn_to_port;
      dn_posted <= next_dn_posted;
      dn_kind <= next_dn_kind;
      dn_addr <= next_dn_addr;
      dn_be <= next_dn_be;
      dn_wdata <= next_dn_wdata;
    end
  end

  // Inbound I/O and config requests
  always_comb begin
    next_in_mem_rd = in_req && in_is_io_cfg;
    next_in_mem_addr = `HLD_UR_ADDR;
    next_in_ur = in_req && in_is_io_cfg;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_mem_rd <= 1'b0;
      in_mem_addr <= 32'h0;
      in_ur <= 1'b0;
    end else begin
      in_mem_rd <= next_in_mem_rd;
      in_mem_addr <= next_in_mem_addr;
      in_ur <= next_in_ur;
    end
  end

  io_split_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st == HLD_S_LOW && dn_done && kind == HLD_K_IO_RD &&
     be[3:0] != 4'h0 && be[7:4] != 4'h0) |=>
    dn_req && dn_addr[2] && st == HLD_S_HIGH)
    else $error("crossing read not split");
  post_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    dn_req |-> (dn_posted == (dn_kind == HLD_K_MEM_WR)))
    else $error("posting wrong");
  io_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (dn_req && !cmd[`HLD_CMD_IO_EN_BIT] && dn_kind[1] == 1'b0 &&
     $stable(cmd)) |-> !dn_to_port)
    else $error("I/O sent to disabled port");
  in_ur_a: assert property (@(posedge clk_sys) disable iff (rst)
    (in_req && in_is_io_cfg) |=> in_ur && in_mem_rd && in_mem_addr == 32'h0)
    else $error("inbound not UR");
  cfg_claim_a: assert property (@(posedge clk_sys) disable iff (rst)
    (host_req && !host_busy && dst == HLD_DST_CFG) |=> host_done && !dn_req)
    else $error("config port forwarded");
  done_bnd_a: assert property (@(posedge clk_sys) disable iff (rst)
    (host_req && !host_busy && st == HLD_S_IDLE) |=> (host_done || dn_req))
    else $error("I/O neither claimed nor forwarded");
  addr_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st == HLD_S_IDLE && host_req && !host_busy && dn_req == 1'b0 &&
     dst == HLD_DST_SOUTH) |=>
    {dn_addr[31:3], 3'h0} == ($past(full_addr) & 32'hfffffff8))
    else $error("address altered");
  win_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st == HLD_S_IDLE && host_req && !host_busy && req_io &&
     dst != HLD_DST_CFG) |=> dn_to_port == $past(win_hit))
    else $error("window routing wrong");
endmodule : hld_top

/* File: tb/hld_link_model.sv */
// Purpose: Downstream link model answering forwarded requests
// Assumes: One request outstanding, latency set by the bench
// Notes: Read data garble while no completion stands
`timescale 1ns/1ps
module hld_link_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire logic dn_req,
  input wire logic [31:0] dn_addr,
  output logic dn_done,
  output logic [31:0] dn_rdata
);
  logic [3:0] cnt;
  logic [31:0] addr_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      addr_q <= 32'h0;
      dn_done <= 1'b0;
      dn_rdata <= 32'h5a5a5a5a;
    end else begin
      dn_done <= 1'b0;
      dn_rdata <= ~dn_rdata;
      if (dn_req) begin
        cnt <= lat;
        addr_q <= dn_addr;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          dn_done <= 1'b1;
          dn_rdata <= addr_q[2] ? 32'hff000000 : 32'h000000ff;
        end
      end
    end
  end
endmodule : hld_link_model

/* File: tb/host_io_legacy_decode_test.sv */
// Purpose: Self-checking bench for the host I/O and legacy decode
// Assumes: Link model answers every forwarded request
// Notes: Expected routes follow the decode order
`timescale 1ns/1ps
module host_io_legacy_decode_test
  import hld_pkg::*;
;
  logic clk_sys, rst, reg_wr, reg_rd, host_req, b16n, host_busy;
  logic host_done, dn_req, dn_to_port, dn_posted, dn_done;
  logic in_req, in_io, in_mem_rd, in_ur;
  logic [3:0] reg_addr, dn_be, lat;
  logic [1:0] host_kind, dn_kind;
  logic [7:0] host_be;
  logic [31:0] reg_wdata, reg_rdata, host_addr, host_wdata, host_rdata;
  logic [31:0] dn_addr, dn_wdata, dn_rdata, in_mem_addr;
  logic [31:0] rd, f_addr, l_addr;
  logic [3:0] f_be, l_be;
  logic l_port, l_posted;
  logic [1:0] l_kind;
  int err_count, n_compared, n_dn;
  logic [1:0] t_lac [8] = '{0, 1, 1, 1, 1, 3, 3, 3};
  logic [31:0] t_adr [8] = '{32'h000a0000, 32'h000a0000, 32'h000bfff8,
    32'h000b0000, 32'h0009fff8, 32'h000b7ff8, 32'h000b8000, 32'h000afff8};
  logic t_prt [8] = '{0, 1, 1, 1, 0, 0, 1, 1};

  hld_top hld_top_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .host_req(host_req), .host_kind(host_kind),
    .host_addr(host_addr), .host_addr_bit16_n(b16n), .host_be(host_be),
    .host_wdata(host_wdata), .host_busy(host_busy), .host_done(host_done),
    .host_rdata(host_rdata), .dn_req(dn_req), .dn_to_port(dn_to_port),
    .dn_posted(dn_posted), .dn_kind(dn_kind), .dn_addr(dn_addr),
    .dn_be(dn_be), .dn_wdata(dn_wdata), .dn_done(dn_done),
    .dn_rdata(dn_rdata), .in_req(in_req), .in_is_io_cfg(in_io),
    .in_mem_rd(in_mem_rd), .in_mem_addr(in_mem_addr), .in_ur(in_ur));
  hld_link_model hld_link_model_i (.clk_sys(clk_sys), .rst(rst), .lat(lat),
    .dn_req(dn_req), .dn_addr(dn_addr), .dn_done(dn_done),
    .dn_rdata(dn_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Record each downstream transaction as it stands
  always @(posedge clk_sys) begin
    if (dn_req === 1'b1) begin
      if (n_dn == 0) begin
        f_addr = dn_addr;
        f_be = dn_be;
      end
      n_dn = n_dn + 1;
      l_addr = dn_addr;
      l_be = dn_be;
      l_port = dn_to_port;
      l_posted = dn_posted;
      l_kind = dn_kind;
    end
  end

  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_reg

  task host_op(input hld_kind_e k, input logic [31:0] a, input logic n16,
               input logic [7:0] be, input logic [31:0] wd);
    int i;
    n_dn = 0;
    @(posedge clk_sys);
    host_req <= 1'b1;
    host_kind <= k;
    host_addr <= a;
    b16n <= n16;
    host_be <= be;
    host_wdata <= wd;
    @(posedge clk_sys);
    host_req <= 1'b0;
    #1;
    for (i = 0; i < 60 && host_done !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (host_done !== 1'b1) begin
      err_count++;
      $display("unexpected %0t no host completion", $time);
      give_verdict();
    end
    rd = host_rdata;
    b16n <= 1'b1;
  endtask : host_op

  task route(input hld_kind_e k, input logic [31:0] a, input logic p);
    host_op(k, a, ~a[16], 8'h0f, 32'h0);
    chk(32'(n_dn), 32'h1);
    chk({31'h0, l_port}, {31'h0, p});
    chk(l_addr, a);
    chk({31'h0, host_busy}, 32'h0);
  endtask : route

  task inbound(input logic q);
    @(posedge clk_sys);
    in_req <= 1'b1;
    in_io <= q;
    @(posedge clk_sys);
    in_req <= 1'b0;
    #1 chk({30'h0, in_ur, in_mem_rd}, q ? 32'h3 : 32'h0);
    chk(in_mem_addr, 32'h0);
  endtask : inbound

  initial begin
    {rst, reg_wr, reg_rd, host_req, in_req, in_io} = 6'h20;
    {reg_addr, reg_wdata, host_kind, host_addr, host_be} = '0;
    host_wdata = 32'h0;
    b16n = 1'b1;
    lat = 4'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(4'h0, 32'h0000ffff);
    rd_reg(4'h1, 32'h0);
    rd_reg(4'h2, 32'h0);
    rd_reg(4'h3, 32'h0);
    rd_reg(4'h4, 32'h01000000);
    rd_reg(4'hf, 32'h0);
    host_op(HLD_K_IO_WR, 32'h0cf8, 1'b1, 8'h0f, 32'h80001234);
    chk(32'(n_dn), 32'h0);
    host_op(HLD_K_IO_RD, 32'h0cf8, 1'b1, 8'h0f, 32'h0);
    chk(rd, 32'h80001234);
    chk(32'(n_dn), 32'h0);
    host_op(HLD_K_IO_RD, 32'h0cf8, 1'b1, 8'hf0, 32'h0);
    chk(32'(n_dn), 32'h0);
    rd_reg(4'h5, 32'h80001234);
    route(HLD_K_IO_RD, 32'h00000080, 1'b0);
    wr_reg(4'h0, 32'h1000);
    wr_reg(4'h1, 32'h1ff8);
    rd_reg(4'h0, 32'h1000);
    route(HLD_K_IO_RD, 32'h1000, 1'b0);
    wr_reg(4'h2, 32'h3);
    route(HLD_K_IO_RD, 32'h1000, 1'b1);
    route(HLD_K_IO_RD, 32'h1ff8, 1'b1);
    route(HLD_K_IO_RD, 32'h2000, 1'b0);
    route(HLD_K_IO_RD, 32'h0ff8, 1'b0);
    lat <= 4'h6;
    host_op(HLD_K_IO_WR, 32'h1008, 1'b1, 8'h0f, 32'hcafe0001);
    chk({31'h0, l_posted}, 32'h0);
    chk({30'h0, l_kind}, 32'h1);
    chk(dn_wdata, 32'hcafe0001);
    host_op(HLD_K_IO_RD, 32'h0080, 1'b1, 8'h18, 32'h0);
    chk(32'(n_dn), 32'h2);
    chk({f_addr[27:0], f_be}, {28'h0000080, 4'h8});
    chk({l_addr[27:0], l_be}, {28'h0000084, 4'h1});
    chk(rd, 32'hff0000ff);
    rd_reg(4'h6, 32'h1);
    for (int i = 0; i < 2; i++) begin
      host_op(HLD_K_IO_WR, 32'h0080, 1'b1, i ? 8'h10 : 8'h08, 32'h1);
      chk(32'(n_dn), 32'h1);
      chk({24'h0, l_addr[3:0], l_be}, i ? 32'h41 : 32'h08);
    end
    lat <= 4'h1;
    host_op(HLD_K_IO_RD, 32'h0, 1'b0, 8'h01, 32'h0);
    chk(l_addr, 32'h00010000);
    for (int i = 0; i < 8; i++) begin
      wr_reg(4'h3, {30'h0, t_lac[i]});
      route(HLD_K_MEM_RD, t_adr[i], t_prt[i]);
    end
    wr_reg(4'h3, 32'h1);
    host_op(HLD_K_MEM_WR, 32'h000a0000, 1'b1, 8'h0f, 32'h7);
    chk({31'h0, l_posted}, 32'h1);
    wr_reg(4'h4, 32'h02000000);
    host_op(HLD_K_MEM_RD, 32'h01000000, 1'b1, 8'h0f, 32'h0);
    chk(32'(n_dn), 32'h0);
    route(HLD_K_MEM_RD, 32'h02000000, 1'b0);
    inbound(1'b1);
    inbound(1'b0);
    give_verdict();
  end
endmodule : host_io_legacy_decode_test
